// *** dgcs_top.sv ***
// Purpose: DMA global control and status registers with the channel 3 pointer tail, on AHB-Lite
// Assumes: Engine-side inputs come from logic on clk_in; single whole-word transfers
// Notes: Reads take one wait state, writes take none
//
// Summary of operation
// - Each register answers at base plus 0x4, 0x8 and 0xc, where written ones clear, set or invert bits, except status, which ignores all writes.
// - The channel 3 source, destination, cell size, cell pointer and pattern registers reset to zero.
// - Unimplemented bits, including control bits 31 to 16, always read as zero.
// - Control bit 15 enables the whole DMA module when one and disables it when zero.
// - While control bit 12 is one all transfers are suspended so the CPU owns the data bus.
// - Control bit 11 reads one while the module is active and zero when disabled and idle.
// - Status bit 3 reads one when the last DMA bus access was a read and zero for a write.
// - Status bits 2 to 0 are read-only and hold the most recently active channel number.
// - All implemented control and status bits except control bit 11, which reads xfer_active_in, come out of reset cleared.
`timescale 1ns/100ps
`include "dgcs_regs.svh"

module dgcs_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic dma_access_in,
  input wire logic dma_access_read_in,
  input wire dgcs_pkg::dgcs_chan_t dma_access_chan_in,
  input wire logic xfer_active_in,
  output logic module_enable_out,
  output logic suspend_out,
  output logic transfer_grant_out,
  output logic [15:0] source_pointer_field_out,
  output logic [15:0] destination_pointer_field_out,
  output logic [15:0] cell_size_field_out,
  output logic [15:0] cell_pointer_field_out,
  output logic [7:0] pattern_data_field_out
);
  import dgcs_pkg::*;

  // Applies a plain, clear, set or invert write to a register value
  function automatic logic [31:0] apply_write(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [1:0] kind,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = wdata;
    case (kind)
      DGCS_WR_PLAIN: res = wdata;
      DGCS_WR_CLR: res = old_val & ~wdata;
      DGCS_WR_SET: res = old_val | wdata;
      DGCS_WR_INV: res = old_val ^ wdata;
      default: res = wdata;
    endcase
    apply_write = res & mask;
  endfunction

  // True when the captured address falls in the four-word group of a register
  function automatic logic reg_hit(
    input logic [`DGCS_ADDR_W-1:0] addr,
    input logic [`DGCS_ADDR_W-1:0] off
  );
    reg_hit = ({addr[`DGCS_ADDR_W-1:4], 4'h0} == off);
  endfunction

  // Control readback word built from its field positions
  function automatic logic [31:0] ctl_pack(
    input logic on,
    input logic suspend,
    input logic busy
  );
    logic [31:0] res;
    res = `DGCS_RESET_VAL;
    res[`DGCS_CTL_ON_BIT] = on;
    res[`DGCS_CTL_SUSPEND_BIT] = suspend;
    res[`DGCS_CTL_BUSY_BIT] = busy;
    ctl_pack = res;
  endfunction

  // Status readback word built from its field positions
  function automatic logic [31:0] stat_pack(
    input logic dir,
    input dgcs_chan_t chan
  );
    logic [31:0] res;
    res = `DGCS_RESET_VAL;
    res[`DGCS_STAT_DIR_BIT] = dir;
    res[`DGCS_STAT_CH_LSB +: $bits(dgcs_chan_t)] = chan;
    stat_pack = res;
  endfunction

  // Places a field in the low bits of a word and clears the rest
  function automatic logic [31:0] low_field(
    input logic [15:0] val,
    input logic [31:0] mask
  );
    low_field = {16'h0000, val} & mask;
  endfunction

  dgcs_bus_state_e state;
  dgcs_bus_state_e next_state;
  logic [`DGCS_ADDR_W-1:0] addr_q;
  logic ctl_on;
  logic ctl_suspend;
  logic last_access_direction;
  dgcs_chan_t last_active_channel;
  logic [15:0] ch3_source_pointer;
  logic [15:0] ch3_destination_pointer;
  logic [15:0] ch3_cell_size;
  logic [15:0] ch3_cell_pointer;
  logic [7:0] ch3_pattern_data;

  // Address phase acceptance
  wire addr_accept = hsel_in & htrans_in[1] & hready_in;

  // Register select from the captured address, alias kind from bits 3:2
  wire [1:0] alias_kind = addr_q[3:2];
  wire hit_ctl = reg_hit(addr_q, `DGCS_CTL_OFF);
  wire hit_stat = reg_hit(addr_q, `DGCS_STAT_OFF);
  wire hit_sptr = reg_hit(addr_q, `DGCS_SPTR_OFF);
  wire hit_dptr = reg_hit(addr_q, `DGCS_DPTR_OFF);
  wire hit_csiz = reg_hit(addr_q, `DGCS_CSIZ_OFF);
  wire hit_cptr = reg_hit(addr_q, `DGCS_CPTR_OFF);
  wire hit_pdat = reg_hit(addr_q, `DGCS_PDAT_OFF);
  wire wr_now = (state == DGCS_ST_WRITE);

  // Per-register write strobes; status has none, so writes to it are dropped
  wire wr_ctl = wr_now & hit_ctl;
  wire wr_sptr = wr_now & hit_sptr;
  wire wr_dptr = wr_now & hit_dptr;
  wire wr_csiz = wr_now & hit_csiz;
  wire wr_cptr = wr_now & hit_cptr;
  wire wr_pdat = wr_now & hit_pdat;

  // Module stays active while enabled or while a transfer is still draining
  wire module_active_flag = ctl_on | xfer_active_in;

  // Readback images; unimplemented bits are zero
  wire [31:0] ctl_image = ctl_pack(ctl_on, ctl_suspend, module_active_flag);
  wire [31:0] stat_image = stat_pack(last_access_direction, last_active_channel);
  wire [31:0] sptr_image = low_field(ch3_source_pointer, `DGCS_PTR_MASK);
  wire [31:0] dptr_image = low_field(ch3_destination_pointer, `DGCS_PTR_MASK);
  wire [31:0] csiz_image = low_field(ch3_cell_size, `DGCS_PTR_MASK);
  wire [31:0] cptr_image = low_field(ch3_cell_pointer, `DGCS_PTR_MASK);
  wire [31:0] pdat_image = low_field({8'h00, ch3_pattern_data}, `DGCS_PDAT_MASK);

  // Unmapped addresses read as zero
  wire [31:0] read_value =
    hit_ctl ? ctl_image :
    hit_stat ? stat_image :
    hit_sptr ? sptr_image :
    hit_dptr ? dptr_image :
    hit_csiz ? csiz_image :
    hit_cptr ? cptr_image :
    hit_pdat ? pdat_image : 32'h00000000;

  // Write results through the alias decode
  wire [31:0] ctl_new = apply_write(ctl_image, hwdata_in, alias_kind, `DGCS_CTL_WMASK);
  wire [31:0] sptr_new = apply_write(sptr_image, hwdata_in, alias_kind, `DGCS_PTR_MASK);
  wire [31:0] dptr_new = apply_write(dptr_image, hwdata_in, alias_kind, `DGCS_PTR_MASK);
  wire [31:0] csiz_new = apply_write(csiz_image, hwdata_in, alias_kind, `DGCS_PTR_MASK);
  wire [31:0] cptr_new = apply_write(cptr_image, hwdata_in, alias_kind, `DGCS_PTR_MASK);
  wire [31:0] pdat_new = apply_write(pdat_image, hwdata_in, alias_kind, `DGCS_PDAT_MASK);

  // Bus state sequencing
  always_comb begin
    next_state = DGCS_ST_IDLE;
    case (state)
      DGCS_ST_READ: next_state = DGCS_ST_RDOUT;
      DGCS_ST_IDLE, DGCS_ST_WRITE, DGCS_ST_RDOUT: begin
        if (addr_accept) begin
          next_state = hwrite_in ? DGCS_ST_WRITE : DGCS_ST_READ;
        end else begin
          next_state = DGCS_ST_IDLE;
        end
      end
      default: next_state = DGCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= DGCS_ST_IDLE;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      state <= next_state;
      hreadyout_out <= (next_state != DGCS_ST_READ);
      hresp_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_q <= {`DGCS_ADDR_W{1'b0}};
    end else if (addr_accept) begin
      addr_q <= haddr_in[`DGCS_ADDR_W-1:0];
    end
  end

  // Read data loaded during the wait state, held until the next read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hrdata_out <= 32'h00000000;
    end else if (state == DGCS_ST_READ) begin
      hrdata_out <= read_value;
    end
  end

  // Control register; the busy bit is not stored
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl_on <= 1'(`DGCS_RESET_VAL);
    end else if (wr_ctl) begin
      ctl_on <= ctl_new[`DGCS_CTL_ON_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl_suspend <= 1'(`DGCS_RESET_VAL);
    end else if (wr_ctl) begin
      ctl_suspend <= ctl_new[`DGCS_CTL_SUSPEND_BIT];
    end
  end

  // Status tracks each engine access; software writes are ignored
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_access_direction <= 1'(`DGCS_RESET_VAL);
    end else if (dma_access_in) begin
      last_access_direction <= dma_access_read_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_active_channel <= dgcs_chan_t'(`DGCS_RESET_VAL);
    end else if (dma_access_in) begin
      last_active_channel <= dma_access_chan_in;
    end
  end

  // Channel 3 tail registers, one short process each
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ch3_source_pointer <= 16'(`DGCS_RESET_VAL);
    end else if (wr_sptr) begin
      ch3_source_pointer <= sptr_new[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ch3_destination_pointer <= 16'(`DGCS_RESET_VAL);
    end else if (wr_dptr) begin
      ch3_destination_pointer <= dptr_new[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ch3_cell_size <= 16'(`DGCS_RESET_VAL);
    end else if (wr_csiz) begin
      ch3_cell_size <= csiz_new[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ch3_cell_pointer <= 16'(`DGCS_RESET_VAL);
    end else if (wr_cptr) begin
      ch3_cell_pointer <= cptr_new[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ch3_pattern_data <= 8'(`DGCS_RESET_VAL);
    end else if (wr_pdat) begin
      ch3_pattern_data <= pdat_new[7:0];
    end
  end

  // Engine-facing controls, one cycle behind the register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      module_enable_out <= 1'b0;
    end else begin
      module_enable_out <= ctl_on;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      suspend_out <= 1'b0;
    end else begin
      suspend_out <= ctl_suspend;
    end
  end

  // Grant drops while suspended so the CPU keeps the data bus
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      transfer_grant_out <= 1'b0;
    end else begin
      transfer_grant_out <= ctl_on & ~ctl_suspend;
    end
  end

  assign source_pointer_field_out = ch3_source_pointer;
  assign destination_pointer_field_out = ch3_destination_pointer;
  assign cell_size_field_out = ch3_cell_size;
  assign cell_pointer_field_out = ch3_cell_pointer;
  assign pattern_data_field_out = ch3_pattern_data;

endmodule

// *** dgcs_regs.svh ***
// Purpose: Register offsets, field positions and reset values of the DMA global control block
// Assumes: Offsets are byte addresses decoded from the low 14 address bits
// Notes: Each register except status has clear, set and invert aliases at +0x4, +0x8, +0xc; status ignores writes
`ifndef DGCS_REGS_SVH
`define DGCS_REGS_SVH

`define DGCS_ADDR_W 14
`define DGCS_CTL_OFF 14'h3000
`define DGCS_STAT_OFF 14'h3010
`define DGCS_SPTR_OFF 14'h3310
`define DGCS_DPTR_OFF 14'h3320
`define DGCS_CSIZ_OFF 14'h3330
`define DGCS_CPTR_OFF 14'h3340
`define DGCS_PDAT_OFF 14'h3350

`define DGCS_CTL_ON_BIT 15
`define DGCS_CTL_SUSPEND_BIT 12
`define DGCS_CTL_BUSY_BIT 11
`define DGCS_STAT_DIR_BIT 3
`define DGCS_STAT_CH_LSB 0
`define DGCS_CTL_WMASK 32'h00009000
`define DGCS_PTR_MASK 32'h0000ffff
`define DGCS_PDAT_MASK 32'h000000ff
`define DGCS_RESET_VAL 32'h00000000

`endif

// *** dgcs_pkg.sv ***
// Purpose: Types shared by the DMA global control block
// Assumes: Constants live in dgcs_regs.svh
// Notes: None
package dgcs_pkg;

  typedef enum logic [1:0] {
    DGCS_WR_PLAIN = 2'h0,
    DGCS_WR_CLR = 2'h1,
    DGCS_WR_SET = 2'h2,
    DGCS_WR_INV = 2'h3
  } dgcs_alias_e;

  typedef enum logic [3:0] {
    DGCS_ST_IDLE = 4'h1,
    DGCS_ST_WRITE = 4'h2,
    DGCS_ST_READ = 4'h4,
    DGCS_ST_RDOUT = 4'h8
  } dgcs_bus_state_e;

  typedef logic [2:0] dgcs_chan_t;

endpackage

// *** dgcs_top_sva.sv ***
// Purpose: Port assertions for dgcs_top
// Assumes: One clock domain, hready_in follows hreadyout_out
// Notes: Bound from the bench top
`timescale 1ns/100ps
module dgcs_top_sva (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic module_enable_out,
  input wire logic suspend_out,
  input wire logic transfer_grant_out,
  input wire logic [15:0] source_pointer_field_out,
  input wire logic [7:0] pattern_data_field_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire taken = hsel_in & htrans_in[1] & hready_in;
  wire rd_take = taken & !hwrite_in;
  wire wr_take = taken & hwrite_in;
  sequence s_wait_state;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  chk_read_wait: assert property (rd_take |=> s_wait_state) else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_take |=> hreadyout_out) else $error("write inserted a wait state");
  chk_resp_okay: assert property (hresp_out == 1'b0) else $error("response not okay");
  chk_grant_rule: assert property (transfer_grant_out == (module_enable_out & !suspend_out))
    else $error("grant disagrees with enable and suspend");
  chk_enable_cause: assert property ($changed(module_enable_out) |-> $past(wr_take, 3))
    else $error("enable moved without a write");
  chk_suspend_cause: assert property ($changed(suspend_out) |-> $past(wr_take, 3))
    else $error("suspend moved without a write");
  chk_ptr_cause: assert property ($changed(source_pointer_field_out) |-> $past(wr_take, 2))
    else $error("source pointer moved without a write");
  chk_pdat_cause: assert property ($changed(pattern_data_field_out) |-> $past(wr_take, 2))
    else $error("pattern moved without a write");
  chk_rdata_cause: assert property ($changed(hrdata_out) |-> $past(rd_take, 2))
    else $error("read data moved without a read");
endmodule

// *** dgcs_engine_model.sv ***
// Purpose: Behavioural DMA engine that reports its bus accesses
// Assumes: Accesses are one-cycle pulses on clk_in
// Notes: Direction and channel lines are scrambled once released
`timescale 1ns/100ps
module dgcs_engine_model (
  input wire logic clk_in,
  output logic access_out,
  output logic read_out,
  output dgcs_pkg::dgcs_chan_t chan_out,
  output logic active_out
);
  import dgcs_pkg::*;
  initial begin
    access_out = 1'b0;
    read_out = 1'b0;
    chan_out = 3'h0;
    active_out = 1'b0;
  end
  task automatic access(input logic rd, input dgcs_chan_t ch, input int gap);
    repeat (gap) @(posedge clk_in);
    access_out <= 1'b1;
    read_out <= rd;
    chan_out <= ch;
    @(posedge clk_in);
    access_out <= 1'b0;
    read_out <= ~rd;
    chan_out <= ~ch;
  endtask
  task automatic set_active(input logic v);
    active_out <= v;
    @(posedge clk_in);
  endtask
endmodule

// *** tb_dma_global_control_status.sv ***
// Purpose: Self-checking bench for dgcs_top
// Assumes: Single word AHB-Lite transfers, one slave
// Notes: Engine side comes from dgcs_engine_model
`timescale 1ns/100ps
`include "dgcs_regs.svh"
module tb_dma_global_control_status;
  import dgcs_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  wire hready, hresp, en, sus, gnt, acc, acc_rd, act;
  wire [31:0] hrdata;
  wire [15:0] sp, dp, cs, cp;
  wire [7:0] pd;
  wire dgcs_chan_t acc_ch;
  int error_cnt = 0;
  int compares = 0;
  logic [13:0] offs [7] = '{`DGCS_CTL_OFF, `DGCS_STAT_OFF, `DGCS_SPTR_OFF, `DGCS_DPTR_OFF,
    `DGCS_CSIZ_OFF, `DGCS_CPTR_OFF, `DGCS_PDAT_OFF};
  logic [31:0] al_d [3] = '{32'h0000f00f, 32'h00010001, 32'h000000ff};
  logic [31:0] al_e [3] = '{32'h00000ff0, 32'h00000ff1, 32'h00000f0e};
  always #10 clk_in = ~clk_in;
  dgcs_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .dma_access_in(acc), .dma_access_read_in(acc_rd),
    .dma_access_chan_in(acc_ch), .xfer_active_in(act), .module_enable_out(en), .suspend_out(sus),
    .transfer_grant_out(gnt), .source_pointer_field_out(sp), .destination_pointer_field_out(dp),
    .cell_size_field_out(cs), .cell_pointer_field_out(cp), .pattern_data_field_out(pd));
  dgcs_engine_model u_eng (.clk_in(clk_in), .access_out(acc), .read_out(acc_rd), .chan_out(acc_ch),
    .active_out(act));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    haddr <= {18'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 64);
    q = hrdata;
    if (n >= 64) error_cnt++;
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic test_done;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    foreach (offs[i]) xfer(1'b1, offs[i], 32'hffffffff);
    rd_chk(`DGCS_CTL_OFF, 32'h00009800);
    check({29'h0, en, sus, gnt}, 32'h6);
    rd_chk(`DGCS_STAT_OFF, 32'h0);
    for (int i = 2; i < 7; i++) rd_chk(offs[i], (i < 6) ? 32'h0000ffff : 32'h000000ff);
    check({sp, dp}, 32'hffffffff);
    check({cs, cp}, 32'hffffffff);
    check({24'h0, pd}, 32'h000000ff);
    for (int k = 1; k < 4; k++) begin
      xfer(1'b1, `DGCS_SPTR_OFF + 14'(4 * k), al_d[k-1]);
      rd_chk(`DGCS_SPTR_OFF, al_e[k-1]);
    end
    xfer(1'b1, `DGCS_CTL_OFF + 14'h4, 32'h00001000);
    rd_chk(`DGCS_CTL_OFF, 32'h00008800);
    check({29'h0, en, sus, gnt}, 32'h5);
    xfer(1'b1, `DGCS_CTL_OFF + 14'h4, 32'h00008000);
    @(posedge clk_in);
    rd_chk(`DGCS_CTL_OFF, 32'h0);
    u_eng.set_active(1'b1);
    rd_chk(`DGCS_CTL_OFF, 32'h00000800);
    u_eng.set_active(1'b0);
    xfer(1'b1, `DGCS_CTL_OFF + 14'h8, 32'h00000800);
    rd_chk(`DGCS_CTL_OFF, 32'h0);
    xfer(1'b1, `DGCS_CTL_OFF + 14'hc, 32'h00008000);
    rd_chk(`DGCS_CTL_OFF, 32'h00008800);
    for (int i = 0; i < 8; i++) begin
      u_eng.access(i[0], 3'(i), i % 3 + 1);
      rd_chk(`DGCS_STAT_OFF, {28'h0, i[0], 3'(i)});
    end
    rd_chk(14'h3100, 32'h0);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd_chk(`DGCS_SPTR_OFF, 32'h0);
    rd_chk(`DGCS_STAT_OFF, 32'h0);
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    test_done();
  end
endmodule
bind dgcs_top dgcs_top_sva u_sva (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .hrdata_out(hrdata_out), .module_enable_out(module_enable_out), .suspend_out(suspend_out),
  .transfer_grant_out(transfer_grant_out), .source_pointer_field_out(source_pointer_field_out),
  .pattern_data_field_out(pattern_data_field_out));
